/* common/imp_pkg.sv */
// constants and types shared by the idle-mode / pixel-format command block
// Contract
// - command 0x38, no parameter, clears the idle-mode flag.
// - leave-idle while idle already off changes nothing.
// - command 0x39, no parameter, sets the idle-mode flag.
// - in idle mode only the top bit of each 6-bit colour reaches the panel.
// - enter-idle while idle already on has no effect.
// - idle flag is off after power-on, hardware reset and software reset.
// - command 0x3a takes one parameter byte, stored as pixel format.
// - parameter bits 6..4 are video-stream format, bits 2..0 command-bus format.
// - parameter bits 7 and 3 are ignored.
// - an unused interface's format field is disregarded.
// - a format change affects only later frame-memory writes.
// - pixel format is 18 bpp after power-on and hardware reset, kept on software reset.
// - all three commands are accepted in every operating state.
package imp_pkg;
   localparam logic [7:0] IMP_CMD_IDLE_OFF = 8'h38;
   localparam logic [7:0] IMP_CMD_IDLE_ON  = 8'h39;
   localparam logic [7:0] IMP_CMD_PIXFMT   = 8'h3a;
   localparam int         IMP_VID_LSB      = 4;
   localparam int         IMP_BUS_LSB      = 0;
   localparam int         IMP_FMT_W        = 3;
   // 18 bpp code for both fields
   localparam logic [2:0] IMP_FMT_18BPP    = 3'h6;
   localparam int         IMP_COMP_W       = 6;
   typedef enum logic [0:0] {IMP_ST_CMD, IMP_ST_PARAM} imp_state_t;
endpackage

/* design/imp_colour_gate.sv */
// one colour component: full depth, or msb only while idle
module imp_colour_gate
   import imp_pkg::*;
#(
   parameter int W = IMP_COMP_W
) (
   // control
   input  wire logic         idle,
   // data
   input  wire logic [W-1:0] comp_in,
   output logic [W-1:0]      comp_out
);
   // msb replicated so the eight colours reach full swing
   assign comp_out = idle ? {W{comp_in[W-1]}} : comp_in;
endmodule

/* design/imp_cmd_core.sv */
// command interpreter for idle mode and pixel format
module imp_cmd_core
   import imp_pkg::*;
#(
   parameter int DW = 8
) (
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   // host command bus
   input  wire logic          cmd_data_select,
   input  wire logic          read_strobe_n,
   input  wire logic          write_strobe_n,
   input  wire logic [DW-1:0] bus_data,
   // software reset pulse from the main decoder
   input  wire logic          sw_reset,
   // which interfaces are in use
   input  wire logic          vid_if_used,
   input  wire logic          bus_if_used,
   // pixel stream toward frame memory and panel
   input  wire logic          pix_wr_valid,
   input  wire logic [17:0]   pix_in,
   // state outputs
   output logic               idle_mode,
   output logic [2:0]         vid_pix_fmt,
   output logic [2:0]         bus_pix_fmt,
   output logic               fmt_pending,
   output logic [17:0]        panel_pix
);
   typedef struct packed {
      logic             wr_q;
      imp_state_t       st;
      logic             idle;
      logic [2:0]       vid_fmt;
      logic [2:0]       bus_fmt;
      logic [2:0]       vid_act;
      logic [2:0]       bus_act;
      logic             pend;
      logic [17:0]      pix;
   } imp_core_t;

   imp_core_t q;
   imp_core_t d;
   logic      wr_rise;
   logic      is_cmd;
   logic [17:0] gated;
   logic        param_take;
   logic        param_stray;

   // rising edge of the write strobe, read strobe must be high
   assign wr_rise = write_strobe_n & ~q.wr_q & read_strobe_n;
   assign is_cmd  = ~cmd_data_select;
   // a data byte counts as the format parameter only right after 0x3a
   assign param_take  = wr_rise & ~is_cmd & (q.st == IMP_ST_PARAM);
   assign param_stray = wr_rise & ~is_cmd & (q.st != IMP_ST_PARAM);

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_comp
         imp_colour_gate #(.W(IMP_COMP_W)) u_gate (
            .idle     (q.idle),
            .comp_in  (pix_in[g*IMP_COMP_W +: IMP_COMP_W]),
            .comp_out (gated[g*IMP_COMP_W +: IMP_COMP_W])
         );
      end
   endgenerate

   always_comb begin
      d = q;
      d.wr_q = write_strobe_n;
      // new format takes hold at the next frame-memory write only; done before decode
      // so that a parameter taken in the same cycle keeps its pending flag
      if (pix_wr_valid) begin
         d.vid_act = q.vid_fmt;
         d.bus_act = q.bus_fmt;
         d.pend    = 1'b0;
      end
      // no operating-state input gates decode: commands work in every state
      if (wr_rise) begin
         if (is_cmd) begin
            d.st = IMP_ST_CMD;
            case (bus_data[7:0])
               IMP_CMD_IDLE_OFF: d.idle = 1'b0;
               IMP_CMD_IDLE_ON:  d.idle = 1'b1;
               IMP_CMD_PIXFMT:   d.st = IMP_ST_PARAM;
               default:          d.st = IMP_ST_CMD;
            endcase
         end else begin
            case (q.st)
               IMP_ST_PARAM: begin
                  // bits 7 and 3 are dropped here
                  if (vid_if_used) begin
                     d.vid_fmt = bus_data[IMP_VID_LSB +: IMP_FMT_W];
                  end
                  if (bus_if_used) begin
                     d.bus_fmt = bus_data[IMP_BUS_LSB +: IMP_FMT_W];
                  end
                  d.pend = 1'b1;
                  d.st   = IMP_ST_CMD;
               end
               default: d.st = IMP_ST_CMD;
            endcase
         end
      end
      d.pix = gated;
      if (sw_reset) begin
         d.idle = 1'b0;
         d.st   = IMP_ST_CMD;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q.wr_q    <= 1'b1;
         q.st      <= IMP_ST_CMD;
         q.idle    <= 1'b0;
         q.vid_fmt <= IMP_FMT_18BPP;
         q.bus_fmt <= IMP_FMT_18BPP;
         q.vid_act <= IMP_FMT_18BPP;
         q.bus_act <= IMP_FMT_18BPP;
         q.pend    <= 1'b0;
         q.pix     <= 18'h0;
      end else begin
         q <= d;
      end
   end

   assign idle_mode   = q.idle;
   assign vid_pix_fmt = q.vid_act;
   assign bus_pix_fmt = q.bus_act;
   assign fmt_pending = q.pend;
   assign panel_pix   = q.pix;

   // the flag and the fields move only on an accepted byte, a soft reset or a
   // memory write; each path is pinned down on its own below

   sequence s_leave_idle;
      wr_rise && is_cmd && bus_data[7:0] == IMP_CMD_IDLE_OFF;
   endsequence

   sequence s_enter_idle;
      wr_rise && is_cmd && bus_data[7:0] == IMP_CMD_IDLE_ON;
   endsequence

   sequence s_quiet;
      !sw_reset && !pix_wr_valid;
   endsequence

   sequence s_vid_take;
      param_take && vid_if_used;
   endsequence

   sequence s_bus_take;
      param_take && bus_if_used;
   endsequence

   sequence s_mem_write;
      pix_wr_valid;
   endsequence

   AST_IDLE_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_leave_idle
      |=> !idle_mode)
      else $error("idle not cleared");

   AST_IDLE_ON: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_enter_idle ##0 !sw_reset
      |=> idle_mode)
      else $error("idle not set");

   AST_LEAVE_NOP: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_leave_idle ##0 !idle_mode ##0 s_quiet
      |=> !idle_mode && $stable(vid_pix_fmt) && $stable(bus_pix_fmt) && $stable(fmt_pending))
      else $error("leave idle while off changed state");

   AST_ENTER_NOP: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_enter_idle ##0 idle_mode ##0 s_quiet
      |=> idle_mode && $stable(vid_pix_fmt) && $stable(bus_pix_fmt) && $stable(fmt_pending))
      else $error("enter idle while on changed state");

   AST_LEAVE_FMT: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_leave_idle ##0 s_quiet
      |=> $stable(vid_pix_fmt) && $stable(fmt_pending))
      else $error("leave idle touched the format");

   AST_ENTER_FMT: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_enter_idle ##0 s_quiet
      |=> $stable(bus_pix_fmt) && $stable(fmt_pending))
      else $error("enter idle touched the format");

   AST_REFUSED: assert property (@(posedge ref_clk) disable iff (!nrst)
      wr_rise && is_cmd && bus_data[7:0] != IMP_CMD_IDLE_OFF &&
      bus_data[7:0] != IMP_CMD_IDLE_ON && bus_data[7:0] != IMP_CMD_PIXFMT ##0 s_quiet
      |=> $stable(idle_mode) && $stable(fmt_pending) && $stable(vid_pix_fmt))
      else $error("unknown command had an effect");

   AST_SWRST: assert property (@(posedge ref_clk) disable iff (!nrst)
      sw_reset
      |=> !idle_mode)
      else $error("idle survives soft reset");

   // no disable here: the values while reset is held are what this one watches
   AST_RST_VAL: assert property (@(posedge ref_clk)
      !nrst ##1 !nrst
      |-> !idle_mode && !fmt_pending && panel_pix == 18'h0 &&
          vid_pix_fmt == IMP_FMT_18BPP && bus_pix_fmt == IMP_FMT_18BPP)
      else $error("outputs not at reset values");

   AST_FMT_KEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
      sw_reset && !pix_wr_valid
      |=> $stable(vid_pix_fmt) && $stable(bus_pix_fmt))
      else $error("format changed by soft reset");

   AST_SWRST_PEND: assert property (@(posedge ref_clk) disable iff (!nrst)
      sw_reset && !pix_wr_valid && !param_take
      |=> $stable(fmt_pending))
      else $error("pending format lost on soft reset");

   AST_SWRST_ST: assert property (@(posedge ref_clk) disable iff (!nrst)
      sw_reset
      |=> q.st == IMP_ST_CMD)
      else $error("soft reset left a parameter expected");

   AST_GATE: assert property (@(posedge ref_clk) disable iff (!nrst)
      idle_mode
      |=> panel_pix[4:0] == {5{panel_pix[5]}})
      else $error("low red bits leak in idle");

   AST_GATE_GRN: assert property (@(posedge ref_clk) disable iff (!nrst)
      idle_mode
      |=> panel_pix[10:6] == {5{panel_pix[11]}})
      else $error("low green bits leak in idle");

   AST_GATE_BLU: assert property (@(posedge ref_clk) disable iff (!nrst)
      idle_mode
      |=> panel_pix[16:12] == {5{panel_pix[17]}})
      else $error("low blue bits leak in idle");

   AST_IDLE_MSB: assert property (@(posedge ref_clk) disable iff (!nrst)
      idle_mode
      |=> panel_pix[5] == $past(pix_in[5]) && panel_pix[11] == $past(pix_in[11]) &&
          panel_pix[17] == $past(pix_in[17]))
      else $error("idle colour top bit lost");

   AST_FULL_DEPTH: assert property (@(posedge ref_clk) disable iff (!nrst)
      !idle_mode
      |=> panel_pix == $past(pix_in))
      else $error("pixel altered outside idle");

   AST_ARM: assert property (@(posedge ref_clk) disable iff (!nrst)
      wr_rise && is_cmd && bus_data[7:0] == IMP_CMD_PIXFMT && !sw_reset
      |=> q.st == IMP_ST_PARAM)
      else $error("format command not armed");

   AST_PEND: assert property (@(posedge ref_clk) disable iff (!nrst)
      param_take && !pix_wr_valid
      |=> fmt_pending)
      else $error("parameter not taken");

   AST_ONE_PARAM: assert property (@(posedge ref_clk) disable iff (!nrst)
      param_take
      |=> q.st == IMP_ST_CMD)
      else $error("second parameter expected");

   AST_ABANDON: assert property (@(posedge ref_clk) disable iff (!nrst)
      wr_rise && is_cmd && bus_data[7:0] != IMP_CMD_PIXFMT
      |=> q.st == IMP_ST_CMD)
      else $error("command did not abandon format");

   AST_STRAY: assert property (@(posedge ref_clk) disable iff (!nrst)
      param_stray && !pix_wr_valid
      |=> $stable(fmt_pending) && $stable(vid_pix_fmt) && $stable(bus_pix_fmt))
      else $error("stray parameter taken");

   AST_VID_STORE: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_vid_take
      |=> q.vid_fmt == $past(bus_data[6:4]))
      else $error("video field not stored");

   AST_BUS_STORE: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_bus_take
      |=> q.bus_fmt == $past(bus_data[2:0]))
      else $error("bus field not stored");

   AST_FMT: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_vid_take ##1 s_mem_write
      |=> vid_pix_fmt == $past(bus_data[6:4], 2))
      else $error("video format not stored");

   AST_BUS_FMT: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_bus_take ##1 s_mem_write
      |=> bus_pix_fmt == $past(bus_data[2:0], 2))
      else $error("bus format not stored");

   AST_VID_SKIP: assert property (@(posedge ref_clk) disable iff (!nrst)
      param_take && !vid_if_used
      |=> $stable(q.vid_fmt))
      else $error("unused video field taken");

   AST_BUS_SKIP: assert property (@(posedge ref_clk) disable iff (!nrst)
      param_take && !bus_if_used
      |=> $stable(q.bus_fmt))
      else $error("unused bus field taken");

   AST_NO_EARLY: assert property (@(posedge ref_clk) disable iff (!nrst)
      !pix_wr_valid
      |=> $stable(vid_pix_fmt))
      else $error("format changed without memory write");

   AST_BUS_EARLY: assert property (@(posedge ref_clk) disable iff (!nrst)
      !pix_wr_valid
      |=> $stable(bus_pix_fmt))
      else $error("bus format changed without memory write");

   AST_PEND_CLR: assert property (@(posedge ref_clk) disable iff (!nrst)
      pix_wr_valid && !param_take
      |=> !fmt_pending)
      else $error("pending flag not cleared by memory write");

   AST_RD_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
      !read_strobe_n ##0 s_quiet
      |=> $stable(idle_mode) && $stable(fmt_pending))
      else $error("byte taken while read strobe low");
endmodule

/* tb/imp_host.sv */
// host processor model driving the parallel command bus
module imp_host (
   input  wire logic clk,
   output logic       sel,
   output logic       rd_n,
   output logic       wr_n,
   output logic [7:0] data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sel = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      data = 8'h00;
   end
   // one byte: strobe low one cycle, then high two cycles before the next byte
   task automatic put(input logic s, input logic [7:0] b);
      @(posedge clk);
      sel  <= s;
      data <= b;
      wr_n <= 1'b0;
      @(posedge clk);
      wr_n <= 1'b1;
      @(posedge clk);
      data <= ~b; // a released bus does not keep the last byte
   endtask
   task automatic fmt(input logic [7:0] p);
      put(1'b0, 8'h3a);
      put(1'b1, p);
   endtask
endmodule

/* tb/idle_mode_pixel_format_cmds_tb.sv */
// self-checking bench for the idle-mode and pixel-format commands
module idle_mode_pixel_format_cmds_tb;
   import imp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, nrst = 1'b0, sw_reset = 1'b0, vid_used = 1'b1, bus_used = 1'b1;
   logic pix_v = 1'b0, sel, rd_n, wr_n, idle, pend;
   logic [7:0] dat;
   logic [2:0] vfmt, bfmt;
   logic [17:0] pix_in = 18'h00000, panel;
   int err_total = 0, tests_run = 0;
   always #10 ref_clk = ~ref_clk;
   imp_host i_imp_host (.clk(ref_clk), .sel(sel), .rd_n(rd_n), .wr_n(wr_n), .data(dat));
   imp_cmd_core i_imp_cmd_core (.ref_clk(ref_clk), .nrst(nrst), .cmd_data_select(sel),
      .read_strobe_n(rd_n), .write_strobe_n(wr_n), .bus_data(dat), .sw_reset(sw_reset),
      .vid_if_used(vid_used), .bus_if_used(bus_used), .pix_wr_valid(pix_v), .pix_in(pix_in),
      .idle_mode(idle), .vid_pix_fmt(vfmt), .bus_pix_fmt(bfmt), .fmt_pending(pend),
      .panel_pix(panel));
   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr_pix();
      @(posedge ref_clk) pix_v <= 1'b1;
      @(posedge ref_clk) pix_v <= 1'b0;
      cyc(1);
   endtask
   task automatic cmd(input logic [7:0] c, input logic e);
      i_imp_host.put(1'b0, c);
      cyc(2);
      chk("idle", {17'h0, e}, idle);
   endtask
   task automatic end_sim();
      if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #200us;
      err_total++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      cyc(2);
      chk("idle", 18'h0, idle);
      chk("fmt", {12'h0, IMP_FMT_18BPP, IMP_FMT_18BPP}, {12'h0, vfmt, bfmt});
      i_imp_host.put(1'b1, 8'h11);
      cyc(2);
      chk("pend", 18'h0, pend);
      cmd(IMP_CMD_IDLE_ON, 1'b1);
      cmd(IMP_CMD_IDLE_ON, 1'b1);
      @(posedge ref_clk) pix_in <= {6'h20, 6'h1f, 6'h3f};
      cyc(2);
      chk("panel", {6'h3f, 6'h00, 6'h3f}, panel);
      i_imp_host.fmt(8'hd5);
      cyc(2);
      chk("pend", 18'h1, pend);
      chk("fmt", {12'h0, IMP_FMT_18BPP, IMP_FMT_18BPP}, {12'h0, vfmt, bfmt});
      wr_pix();
      chk("fmt", 18'h2d, {12'h0, vfmt, bfmt});
      chk("pend", 18'h0, pend);
      @(posedge ref_clk) bus_used <= 1'b0;
      i_imp_host.fmt(8'h12);
      wr_pix();
      chk("fmt", 18'h0d, {12'h0, vfmt, bfmt});
      i_imp_host.put(1'b0, IMP_CMD_PIXFMT);
      cmd(8'h00, 1'b1);
      i_imp_host.put(1'b1, 8'h77);
      cyc(2);
      chk("pend", 18'h0, pend);
      @(posedge ref_clk) sw_reset <= 1'b1;
      @(posedge ref_clk) sw_reset <= 1'b0;
      cyc(1);
      chk("idle", 18'h0, idle);
      chk("fmt", 18'h0d, {12'h0, vfmt, bfmt});
      cmd(IMP_CMD_IDLE_ON, 1'b1);
      cmd(IMP_CMD_IDLE_OFF, 1'b0);
      cmd(IMP_CMD_IDLE_OFF, 1'b0);
      chk("panel", {6'h20, 6'h1f, 6'h3f}, panel);
      @(posedge ref_clk) nrst <= 1'b0;
      cyc(2);
      @(posedge ref_clk) nrst <= 1'b1;
      cyc(2);
      chk("fmt", {12'h0, IMP_FMT_18BPP, IMP_FMT_18BPP}, {12'h0, vfmt, bfmt});
      end_sim();
   end
endmodule
